// [hw/cesf_pkg.sv]
// Purpose: Constants for the CAN error status and receive filter-hit block
// Assumes: 8-bit register port, 25 MHz clock
// Notes: Register offsets are local to this block
// What this block does
// - Bus-off flag set when transmit error count exceeds 255.
// - Transmit error-passive flag set when transmit count above 127.
// - Receive error-passive flag set when receive count above 127.
// - Transmit warning flag set when transmit count above 95.
// - Legacy mode buffer 1 hit code 010..101 for filters 2..5.
// - Codes 000/001 in buffer 1 only with double-buffering enabled.
// - Enhanced modes report five-bit hit code, filters 0..15.
// - Full flag set when a message is stored into a buffer.
// - Full buffer takes no new message; software clears flag after reading.
// - Interrupt code gives highest pending source: none, error, tx2..tx0, rx1, rx0.
// - Code 111 reports wake-up; software clears the wake-up flag.
// - Configuration request waits for bus idle; software polls mode status.
// - Other mode requests are honoured immediately.
// - Software requests a three-bit mode; status shows mode entered, 001 disable.
// - Configuration mode blocks traffic, clears counters, keeps interrupt flags.
package cesf_pkg;
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_RXB1 = 4'h1;
	localparam logic [3:0] ADDR_RXB0 = 4'h2;
	localparam logic [3:0] ADDR_CONTROL = 4'h3;
	localparam logic [3:0] ADDR_CSTAT = 4'h4;
	localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h5;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
	localparam logic [3:0] ADDR_CFG = 4'h7;
	localparam logic [3:0] ADDR_TEC = 4'h8;
	localparam logic [3:0] ADDR_REC = 4'h9;
	localparam logic [8:0] TX_BUS_OFF_LIMIT = 9'h0ff;
	localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
	localparam logic [8:0] WARN_LIMIT = 9'h05f;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_DISABLE = 3'h1;
	localparam logic [2:0] MODE_CONFIG = 3'h4;
	localparam logic [2:0] MODE_RESET = 3'h4;
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_ERR = 3'h1;
	localparam logic [2:0] CODE_TX2 = 3'h2;
	localparam logic [2:0] CODE_TX1 = 3'h3;
	localparam logic [2:0] CODE_TX0 = 3'h4;
	localparam logic [2:0] CODE_RX1 = 3'h5;
	localparam logic [2:0] CODE_RX0 = 3'h6;
	localparam logic [2:0] CODE_WAKE = 3'h7;
	localparam int IRQ_ERR = 0;
	localparam int IRQ_TX2 = 1;
	localparam int IRQ_TX1 = 2;
	localparam int IRQ_TX0 = 3;
	localparam int IRQ_RX1 = 4;
	localparam int IRQ_RX0 = 5;
	localparam int IRQ_WAKE = 6;
	localparam int CFG_LEGACY = 0;
	localparam int CFG_DBEN = 1;
	localparam logic [7:0] CFG_RESET = 8'h01;
	typedef enum logic [1:0] {
		CESF_RUN = 2'b01,
		CESF_WAIT_IDLE = 2'b10
	} cesf_mode_e;
endpackage

// [hw/cesf_rx_buffer.sv]
// Purpose: One receive buffer: full interlock, hit code, overflow
// Assumes: Clear strobe from software decoding
// Notes: Set wins over clear in the same cycle
module cesf_rx_buffer (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic store_req,
	input wire logic [4:0] hit_in,
	input wire logic clear_full,
	input wire logic clear_ovfl,
	output logic full,
	output logic ovfl,
	output logic [4:0] hit,
	output logic stored
);
	wire accept = store_req & ~full;
	wire lose = store_req & full;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			full <= 1'b0;
			ovfl <= 1'b0;
			hit <= 5'h00;
			stored <= 1'b0;
		end else begin
			full <= accept | (full & ~clear_full);
			ovfl <= lose | (ovfl & ~clear_ovfl);
			stored <= accept;
			if (accept) begin
				hit <= hit_in;
			end
		end
	end
endmodule

// [hw/cesf_top.sv]
// Purpose: CAN error status, receive filter-hit and mode bookkeeping
// Assumes: Protocol engine supplies counters, accepted messages, bus idle
// Notes: Read data valid the cycle after the read strobe
//
// The register offsets and the plain strobed port were chosen for this implementation.
module cesf_top
	import cesf_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [8:0] TX_ERR_COUNT,
	input wire logic [8:0] RX_ERR_COUNT,
	input wire logic BUS_IDLE,
	input wire logic BUS_ACTIVITY,
	input wire logic MSG_VALID,
	input wire logic [3:0] MSG_FILTER,
	input wire logic ERR_EVENT,
	input wire logic [2:0] TX_DONE,
	output logic [2:0] CUR_MODE,
	output logic ERR_CLEAR,
	output logic LINK_ENABLE,
	output logic IRQ
);
	import cesf_pkg::*;

	// ****************************************
	// Register state
	// ****************************************
	logic [7:0] status;
	logic [2:0] req_mode;
	logic [7:0] irq_flags;
	logic [7:0] irq_mask;
	logic [7:0] cfg;
	cesf_mode_e mstate;
	logic [2:0] op_mode;

	wire wr_status = WR & (ADDR == ADDR_STATUS);
	wire wr_rxb1 = WR & (ADDR == ADDR_RXB1);
	wire wr_rxb0 = WR & (ADDR == ADDR_RXB0);
	wire wr_ctrl = WR & (ADDR == ADDR_CONTROL);
	wire wr_flags = WR & (ADDR == ADDR_IRQ_FLAGS);
	wire wr_mask = WR & (ADDR == ADDR_IRQ_MASK);
	wire wr_cfg = WR & (ADDR == ADDR_CFG) & (op_mode == MODE_CONFIG);
	wire legacy = cfg[CFG_LEGACY];
	wire dben = cfg[CFG_DBEN];
	wire in_config = (op_mode == MODE_CONFIG);
	wire online = (op_mode == MODE_NORMAL);

	// ****************************************
	// Error status flags
	// ****************************************
	wire tx_bus_off_flag = TX_ERR_COUNT > TX_BUS_OFF_LIMIT;
	wire tx_error_passive_flag = TX_ERR_COUNT > PASSIVE_LIMIT;
	wire rx_error_passive_flag = RX_ERR_COUNT > PASSIVE_LIMIT;
	wire tx_warning_flag = TX_ERR_COUNT > WARN_LIMIT;
	wire rx_warning_flag = (RX_ERR_COUNT > WARN_LIMIT) & (RX_ERR_COUNT <= PASSIVE_LIMIT);
	wire combined_warning_flag = tx_warning_flag | rx_warning_flag;

	// ****************************************
	// Receive routing and filter-hit codes
	// ****************************************
	logic b0_full, b1_full, b0_ovfl, b1_ovfl, b0_stored, b1_stored;
	logic [4:0] b0_hit, b1_hit;
	wire rx_ok = MSG_VALID & online;
	wire legacy_f01 = (MSG_FILTER[3:1] == 3'h0);
	wire legacy_ok = ~legacy | (MSG_FILTER <= 4'h5);
	wire to_b0 = rx_ok & legacy_ok & (legacy ? legacy_f01 : ~b0_full);
	wire spill = legacy & legacy_f01 & b0_full & dben;
	wire to_b1 = rx_ok & legacy_ok & ((legacy & ~legacy_f01) | spill | (~legacy & b0_full));
	wire [4:0] hit_code = {1'b0, MSG_FILTER};
	wire [4:0] b0_code = legacy ? {4'h0, MSG_FILTER[0]} : hit_code;
	wire [4:0] b1_code = legacy ? {2'h0, MSG_FILTER[2:0]} : hit_code;
	// Write of zero to bit 7 releases the buffer
	wire clr_b0 = wr_rxb0 & ~WDATA[7];
	wire clr_b1 = wr_rxb1 & ~WDATA[7];
	wire clr_ov0 = wr_status & ~WDATA[7];
	wire clr_ov1 = wr_status & ~WDATA[6];

	cesf_rx_buffer u_rxb0 (
		.CLOCK(CLOCK),
		.RST(RST),
		.store_req(to_b0),
		.hit_in(b0_code),
		.clear_full(clr_b0),
		.clear_ovfl(clr_ov0),
		.full(b0_full),
		.ovfl(b0_ovfl),
		.hit(b0_hit),
		.stored(b0_stored)
	);
	cesf_rx_buffer u_rxb1 (
		.CLOCK(CLOCK),
		.RST(RST),
		.store_req(to_b1),
		.hit_in(b1_code),
		.clear_full(clr_b1),
		.clear_ovfl(clr_ov1),
		.full(b1_full),
		.ovfl(b1_ovfl),
		.hit(b1_hit),
		.stored(b1_stored)
	);

	wire [7:0] next_status = {b0_ovfl, b1_ovfl, tx_bus_off_flag, tx_error_passive_flag,
		rx_error_passive_flag, tx_warning_flag, rx_warning_flag, combined_warning_flag};
	wire [7:0] rxb1_read = legacy ? {b1_full, 4'h0, b1_hit[2:0]} : {b1_full, 2'h0, b1_hit};
	wire [7:0] rxb0_read = {b0_full, 2'h0, b0_hit};

	// ****************************************
	// Interrupt flags and source code
	// ****************************************
	wire [7:0] irq_events = {1'b0, BUS_ACTIVITY & (op_mode == MODE_DISABLE), b0_stored, b1_stored,
		TX_DONE[0], TX_DONE[1], TX_DONE[2], ERR_EVENT & ~in_config};
	wire [7:0] next_flags = irq_events | (irq_flags & ~(wr_flags ? WDATA : 8'h00));
	wire [7:0] pending = irq_flags & irq_mask;
	wire [2:0] interrupt_source_code = pending[IRQ_ERR] ? CODE_ERR :
		pending[IRQ_TX2] ? CODE_TX2 :
		pending[IRQ_TX1] ? CODE_TX1 :
		pending[IRQ_TX0] ? CODE_TX0 :
		pending[IRQ_RX1] ? CODE_RX1 :
		pending[IRQ_RX0] ? CODE_RX0 :
		pending[IRQ_WAKE] ? CODE_WAKE : CODE_NONE;
	wire [7:0] controller_status_reg = {op_mode, 1'b0, interrupt_source_code, 1'b0};

	// ****************************************
	// Mode requests
	// ****************************************
	logic [2:0] next_op_mode;
	cesf_mode_e next_mstate;
	always_comb begin
		next_op_mode = op_mode;
		next_mstate = mstate;
		case (mstate)
			CESF_RUN: begin
				if (req_mode != op_mode) begin
					if (req_mode == MODE_CONFIG && !BUS_IDLE) begin
						next_mstate = CESF_WAIT_IDLE;
					end else begin
						next_op_mode = req_mode;
					end
				end
			end
			CESF_WAIT_IDLE: begin
				if (req_mode != MODE_CONFIG) begin
					next_mstate = CESF_RUN;
				end else if (BUS_IDLE) begin
					next_op_mode = MODE_CONFIG;
					next_mstate = CESF_RUN;
				end
			end
			default: next_mstate = CESF_RUN;
		endcase
	end

	wire [7:0] rd_mux = (ADDR == ADDR_STATUS) ? status :
		(ADDR == ADDR_RXB1) ? rxb1_read :
		(ADDR == ADDR_RXB0) ? rxb0_read :
		(ADDR == ADDR_CONTROL) ? {req_mode, 5'h00} :
		(ADDR == ADDR_CSTAT) ? controller_status_reg :
		(ADDR == ADDR_IRQ_FLAGS) ? irq_flags :
		(ADDR == ADDR_IRQ_MASK) ? irq_mask :
		(ADDR == ADDR_CFG) ? cfg :
		(ADDR == ADDR_TEC) ? TX_ERR_COUNT[7:0] :
		(ADDR == ADDR_REC) ? RX_ERR_COUNT[7:0] : 8'h00;

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			status <= 8'h00;
			req_mode <= MODE_RESET;
			op_mode <= MODE_RESET;
			mstate <= CESF_RUN;
			irq_flags <= 8'h00;
			irq_mask <= 8'h00;
			cfg <= CFG_RESET;
			RDATA <= 8'h00;
			CUR_MODE <= MODE_RESET;
			ERR_CLEAR <= 1'b1;
			LINK_ENABLE <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			status <= next_status;
			op_mode <= next_op_mode;
			mstate <= next_mstate;
			irq_flags <= next_flags;
			if (wr_ctrl) begin
				req_mode <= WDATA[7:5];
			end
			if (wr_mask) begin
				irq_mask <= WDATA;
			end
			if (wr_cfg) begin
				cfg <= WDATA;
			end
			RDATA <= RD ? rd_mux : 8'h00;
			CUR_MODE <= next_op_mode;
			ERR_CLEAR <= next_op_mode == MODE_CONFIG;
			LINK_ENABLE <= next_op_mode == MODE_NORMAL;
			IRQ <= |(next_flags & irq_mask);
		end
	end
endmodule

// [verification/cesf_top_asserts.sv]
// Purpose: Port assertions for the CAN status and filter-hit block
// Assumes: Counters are held steady for two cycles before a status read
// Notes: Bound to every instance of cesf_top
module cesf_top_chk
	import cesf_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [3:0] ADDR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic [8:0] TX_ERR_COUNT,
	input wire logic [8:0] RX_ERR_COUNT,
	input wire logic BUS_IDLE,
	input wire logic [2:0] CUR_MODE,
	input wire logic ERR_CLEAR,
	input wire logic LINK_ENABLE
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	// Steady counters make the status register's one-cycle lag irrelevant
	property p_stat(int b, logic e);
		$past(RD) && $past(ADDR) == ADDR_STATUS && $past(TX_ERR_COUNT) == $past(TX_ERR_COUNT, 2)
			&& $past(RX_ERR_COUNT) == $past(RX_ERR_COUNT, 2) |-> RDATA[b] == e;
	endproperty
	chk_tx_bus_off: assert property (p_stat(5, $past(TX_ERR_COUNT) > TX_BUS_OFF_LIMIT))
		else $error("bus-off flag wrong");
	chk_tx_passive: assert property (p_stat(4, $past(TX_ERR_COUNT) > PASSIVE_LIMIT))
		else $error("tx passive flag wrong");
	chk_rx_passive: assert property (p_stat(3, $past(RX_ERR_COUNT) > PASSIVE_LIMIT))
		else $error("rx passive flag wrong");
	chk_tx_warning: assert property (p_stat(2, $past(TX_ERR_COUNT) > WARN_LIMIT))
		else $error("tx warning flag wrong");
	chk_rx_warning: assert property (p_stat(1, $past(RX_ERR_COUNT) > WARN_LIMIT && $past(RX_ERR_COUNT) <= PASSIVE_LIMIT))
		else $error("rx warning flag wrong");
	chk_any_warning: assert property (p_stat(0, $past(TX_ERR_COUNT) > WARN_LIMIT
		|| ($past(RX_ERR_COUNT) > WARN_LIMIT && $past(RX_ERR_COUNT) <= PASSIVE_LIMIT)))
		else $error("combined warning flag wrong");
	chk_link_normal: assert property (LINK_ENABLE |-> CUR_MODE == MODE_NORMAL)
		else $error("link enabled outside normal mode");
	chk_clear_config: assert property (ERR_CLEAR == (CUR_MODE == MODE_CONFIG))
		else $error("counter clear not tied to config mode");
	chk_config_idle: assert property ($changed(CUR_MODE) && CUR_MODE == MODE_CONFIG
		|-> $past(BUS_IDLE) || $past(BUS_IDLE, 2))
		else $error("config entered on a busy bus");
	chk_read_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read slot");
	cover property ($past(RD) && $past(ADDR) == ADDR_STATUS && RDATA[5]);
	cover property ($rose(CUR_MODE == MODE_CONFIG));
	cover property (LINK_ENABLE ##1 !LINK_ENABLE);
endmodule

bind cesf_top cesf_top_chk i_chk (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
	.TX_ERR_COUNT(TX_ERR_COUNT), .RX_ERR_COUNT(RX_ERR_COUNT), .BUS_IDLE(BUS_IDLE),
	.CUR_MODE(CUR_MODE), .ERR_CLEAR(ERR_CLEAR), .LINK_ENABLE(LINK_ENABLE));

// [verification/cesf_bus_model.sv]
// Purpose: Protocol engine and bus stand-in for the status block
// Assumes: Tasks are called at a rising clock edge
// Notes: Filter lines carry inverted junk between messages
module cesf_bus_model (
	input wire logic CLOCK,
	input wire logic ERR_CLEAR,
	output logic [8:0] TX_ERR_COUNT,
	output logic [8:0] RX_ERR_COUNT,
	output logic BUS_IDLE,
	output logic BUS_ACTIVITY,
	output logic MSG_VALID,
	output logic [3:0] MSG_FILTER,
	output logic ERR_EVENT,
	output logic [2:0] TX_DONE
);
	initial begin
		{TX_ERR_COUNT, RX_ERR_COUNT, BUS_ACTIVITY, MSG_VALID, ERR_EVENT, TX_DONE} = '0;
		// Filter lines carry junk until the first message
		MSG_FILTER = 4'($urandom);
		BUS_IDLE = 1'b1;
	end
	always @(posedge CLOCK) begin
		if (ERR_CLEAR) begin
			TX_ERR_COUNT <= 9'h000;
			RX_ERR_COUNT <= 9'h000;
		end
	end
	task set_cnt(input logic [8:0] t, input logic [8:0] r);
		TX_ERR_COUNT <= t;
		RX_ERR_COUNT <= r;
	endtask
	task idle(input logic v);
		BUS_IDLE <= v;
	endtask
	task send(input logic [3:0] f);
		@(posedge CLOCK);
		MSG_FILTER <= f;
		MSG_VALID <= 1'b1;
		@(posedge CLOCK);
		MSG_VALID <= 1'b0;
		MSG_FILTER <= ~f;
	endtask
	// Event 0 error, 1..3 transmit buffers 2..0, 4 bus activity
	task ev(input int k);
		@(posedge CLOCK);
		ERR_EVENT <= k == 0;
		TX_DONE <= 3'h4 >> (k - 1);
		BUS_ACTIVITY <= k == 4;
		@(posedge CLOCK);
		{ERR_EVENT, TX_DONE, BUS_ACTIVITY} <= 5'h00;
	endtask
endmodule

// [verification/can_error_status_and_rx_filter_hit_bench.sv]
// Purpose: Self-checking bench for cesf_top
// Assumes: 25 MHz clock, register port with one-cycle read data
// Notes: Seed 36 drives the counter sweep
module can_error_status_and_rx_filter_hit_bench import cesf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, wr_s, rd_s, irq, err_clear, link_enable, idle, act, mv, ee;
	logic [3:0] addr, mf;
	logic [7:0] wdata, rdata, v, pins;
	logic [2:0] cur_mode, td;
	logic [8:0] tec, rec, t, r;
	logic [8:0] corner [6] = '{9'h05f, 9'h060, 9'h07f, 9'h080, 9'h0ff, 9'h100};
	int seed = 36, n_mismatch = 0, cmp_count = 0, cyc = 0;
	cesf_top i_dut (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
		.TX_ERR_COUNT(tec), .RX_ERR_COUNT(rec), .BUS_IDLE(idle), .BUS_ACTIVITY(act), .MSG_VALID(mv),
		.MSG_FILTER(mf), .ERR_EVENT(ee), .TX_DONE(td), .CUR_MODE(cur_mode), .ERR_CLEAR(err_clear),
		.LINK_ENABLE(link_enable), .IRQ(irq));
	cesf_bus_model i_bus (.CLOCK(clock), .ERR_CLEAR(err_clear), .TX_ERR_COUNT(tec), .RX_ERR_COUNT(rec),
		.BUS_IDLE(idle), .BUS_ACTIVITY(act), .MSG_VALID(mv), .MSG_FILTER(mf), .ERR_EVENT(ee), .TX_DONE(td));
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report;
		end
	end
	task final_report;
		$display("Mismatches %0d, compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clock);
		wr_s <= 1'b0;
		@(posedge clock);
	endtask
	// Read data and pin levels are taken 1 ns after the answer edge
	task rd(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock);
		rd_s <= 1'b0;
		#1 d = rdata;
		pins = {5'h00, irq, err_clear, link_enable};
		@(posedge clock);
	endtask
	function logic [7:0] stat_exp(input logic [8:0] t, input logic [8:0] r);
		logic tw, rw;
		tw = t > WARN_LIMIT;
		rw = r > WARN_LIMIT && r <= PASSIVE_LIMIT;
		return {2'b00, t > TX_BUS_OFF_LIMIT, t > PASSIVE_LIMIT, r > PASSIVE_LIMIT, tw, rw, tw | rw};
	endfunction
	initial begin
		wr_s = 1'b0;
		rd_s = 1'b0;
		// Address and write data carry junk while no strobe is up
		addr = 4'($random(seed));
		wdata = 8'($random(seed));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(ADDR_CSTAT, v);
		chk(v, 8'h80);
		chk(pins, 8'h02);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_IRQ_MASK, 8'h7f);
		for (int i = 0; i < 16; i++) begin
			t = i < 6 ? corner[i] : 9'($random(seed));
			r = i < 6 ? corner[5 - i] : 9'($random(seed));
			i_bus.set_cnt(t, r);
			repeat (2) @(posedge clock);
			rd(ADDR_STATUS, v);
			chk(v & 8'h3f, stat_exp(t, r));
			chk(pins & 8'h03, 8'h01);
		end
		for (int f = 2; f < 6; f++) begin
			i_bus.send(f[3:0]);
			rd(ADDR_RXB1, v);
			chk(v, {5'h10, f[2:0]});
			wr(ADDR_RXB1, 8'h00);
		end
		i_bus.send(4'h3);
		i_bus.send(4'h4);
		rd(ADDR_RXB1, v);
		chk(v, 8'h83);
		rd(ADDR_STATUS, v);
		chk(v & 8'hc0, 8'h40);
		wr(ADDR_STATUS, 8'h3f);
		rd(ADDR_STATUS, v);
		chk(v, stat_exp(t, r));
		wr(ADDR_RXB1, 8'h00);
		i_bus.send(4'h0);
		i_bus.send(4'h1);
		i_bus.send(4'h6);
		i_bus.send(4'h7);
		// Buffer 1 was released and nothing landed: hit code of filter 3 remains
		rd(ADDR_RXB1, v);
		chk(v, 8'h03);
		rd(ADDR_RXB0, v);
		chk(v, 8'h80);
		wr(ADDR_RXB0, 8'h00);
		wr(ADDR_IRQ_FLAGS, 8'h7f);
		for (int k = 0; k < 4; k++) begin
			i_bus.ev(k);
			rd(ADDR_CSTAT, v);
			chk(v, {4'h0, 3'(k + 1), 1'b0});
			chk(pins, 8'h05);
			wr(ADDR_IRQ_FLAGS, 8'h01 << k);
			rd(ADDR_CSTAT, v);
			chk(v | pins, 8'h01);
		end
		wr(ADDR_IRQ_MASK, 8'h00);
		i_bus.ev(3);
		i_bus.ev(0);
		rd(ADDR_CSTAT, v);
		chk(v | pins, 8'h01);
		wr(ADDR_IRQ_MASK, 8'h7f);
		rd(ADDR_CSTAT, v);
		chk(v, 8'h02);
		wr(ADDR_IRQ_FLAGS, 8'h09);
		wr(ADDR_CONTROL, 8'h20);
		repeat (2) @(posedge clock);
		i_bus.ev(4);
		rd(ADDR_CSTAT, v);
		chk(v, {MODE_DISABLE, 1'b0, CODE_WAKE, 1'b0});
		wr(ADDR_IRQ_FLAGS, 8'h40);
		i_bus.idle(1'b0);
		wr(ADDR_CONTROL, 8'h80);
		repeat (6) @(posedge clock);
		rd(ADDR_CSTAT, v);
		chk(v, {MODE_DISABLE, 5'h00});
		i_bus.idle(1'b1);
		repeat (4) @(posedge clock);
		rd(ADDR_CSTAT, v);
		chk(v, {MODE_CONFIG, 5'h00});
		chk(pins, 8'h02);
		wr(ADDR_CFG, 8'h00);
		wr(ADDR_CONTROL, 8'h00);
		i_bus.send(4'hf);
		i_bus.send(4'hc);
		rd(ADDR_RXB0, v);
		chk(v, 8'h8f);
		rd(ADDR_RXB1, v);
		chk(v, 8'h8c);
		rd(4'hc, v);
		chk(v, 8'h00);
		final_report;
	end
endmodule
